/* File: ldr_pkg.sv */
package ldr_pkg;

  // ----------------------------------------------------------------
  // register offsets on the controller register port
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_ERR_LOW = 5'h05;
  localparam logic [4:0] ADDR_ERR_HIGH = 5'h06;
  localparam logic [4:0] ADDR_PTR = 5'h07;
  localparam logic [4:0] ADDR_DATA = 5'h08;
  localparam logic [4:0] ADDR_TEST_A = 5'h09;
  localparam logic [4:0] ADDR_TEST_B = 5'h0A;

  // ----------------------------------------------------------------
  // sizes, fields and reset values
  // ----------------------------------------------------------------
  localparam int NUM_LINKS = 16;
  localparam int TEST_BITS = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_TEST = 6'h00;
  localparam logic [2:0] FRAME_LAST = 3'h6;
  localparam logic [3:0] PATTERN_LAST = 4'h8;
  localparam logic [3:0] WALK_LAST = 4'h7;
  localparam logic [7:0] WALK_ONE = 8'h01;

  // ----------------------------------------------------------------
  // access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    LDR_IDLE,
    LDR_WAIT_DEV
  } ldr_state_t;

endpackage

/* File: ldr_marker_check.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// frame marker checker for one input link
// ------------------------------------------------------------------
module ldr_marker_check (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sample,
  input wire logic marker,
  input wire logic ref_marker,
  input wire logic synced,
  output logic marker_err,
  output logic align_err
);

  logic [2:0] phase;
  logic [2:0] ones;
  logic [2:0] next_ones;
  logic mis_seen;

  // ones seen so far in the current seven-sample window
  always_comb begin
    next_ones = ones;
    if (marker && ones != 3'h7) begin
      next_ones = ones + 3'h1;
    end
  end

  // free window before sync, same window after; a bad window raises
  // the flag until the next good one closes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 3'h0;
      ones <= 3'h0;
      marker_err <= 1'b0;
    end else if (ce && sample) begin
      if (phase == ldr_pkg::FRAME_LAST) begin
        phase <= 3'h0;
        ones <= 3'h0;
        marker_err <= (next_ones != 3'h1);
      end else begin
        phase <= phase + 3'h1;
        ones <= next_ones;
      end
    end
  end

  // once synced, every sample of a window must match the reference;
  // the verdict stands a whole window so a register read cannot miss it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mis_seen <= 1'b0;
      align_err <= 1'b0;
    end else if (ce && sample) begin
      if (phase == ldr_pkg::FRAME_LAST) begin
        mis_seen <= 1'b0;
        align_err <= mis_seen || (synced && (marker != ref_marker));
      end else begin
        mis_seen <= mis_seen || (synced && (marker != ref_marker));
      end
    end
  end

endmodule

/* File: ldr_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - two read-only link error registers, low/high
// - clock missing, off-frequency or unlocked flags error
// - bad frame marker before sync flags error
// - bad frame marker after sync flags error
// - frames misaligned with reference link flag error
// - latch enable holds error bits once set
// - display mode 14 shows live errors only
// - indirect registers blocked until all configured
// - indirect registers also need access enable set
// - pointer writes copied to all sixteen devices
// - data access hits pointer register, selected device
// - devices keep pointer across device-select changes
// - local registers one command, others indirect
// - test pattern: walking one, then link code
// - pattern repeats forever, start aligned all links
// - group a enable bit to link mapping
// - group b enable bits five to one mapping
// - display mode 13 shows per-link test enables
// - group b bit zero enables links 8, 9
// - latch enable is mode bit 0, reset off
// - access enable is mode bit 2, reset off
// - ready only once every device configured
module ldr_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // controller register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  // mode register bits and device select held elsewhere
  input wire logic latch_enable,
  input wire logic access_enable,
  input wire logic [3:0] device_select,
  input wire logic [15:0] device_done,
  output logic board_ready,
  // per input link status
  input wire logic [15:0] link_clk_missing,
  input wire logic [15:0] link_clk_out_of_range,
  input wire logic [15:0] link_dll_unlocked,
  input wire logic [15:0] link_sample,
  input wire logic [15:0] link_marker,
  input wire logic [15:0] link_synced,
  input wire logic ref_marker,
  // monitoring display feeds
  output logic [15:0] mon_link_error,
  output logic [15:0] mon_test_enable,
  // local bus to the sixteen devices
  output logic [3:0] lb_select,
  output logic [7:0] lb_pointer,
  output logic lb_pointer_wr,
  output logic [7:0] lb_wdata,
  output logic lb_wr,
  output logic lb_rd,
  input wire logic [7:0] lb_rdata,
  input wire logic lb_ack,
  // test pattern transmitter
  input wire logic [1:0] board_position,
  input wire logic pattern_step,
  output logic [15:0] test_pattern_enable,
  output logic [15:0][7:0] test_word
);

  // ----------------------------------------------------------------
  // link error detection
  // ----------------------------------------------------------------
  logic [15:0] marker_err;
  logic [15:0] align_err;
  logic [15:0] live_err;
  logic [15:0] link_err;

  // one window checker per input link
  genvar gi;
  generate
    for (gi = 0; gi < ldr_pkg::NUM_LINKS; gi++) begin : g_link
      ldr_marker_check u_check (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .sample(link_sample[gi]),
        .marker(link_marker[gi]),
        .ref_marker(ref_marker),
        .synced(link_synced[gi]),
        .marker_err(marker_err[gi]),
        .align_err(align_err[gi])
      );
    end
  endgenerate

  // any of the five critical conditions marks the link bad
  assign live_err = link_clk_missing | link_clk_out_of_range | link_dll_unlocked
                  | marker_err | align_err;

  // sticky while latching is on, live again once it is cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_err <= 16'h0000;
    end else if (ce) begin
      if (latch_enable) begin
        link_err <= link_err | live_err;
      end else begin
        link_err <= live_err;
      end
    end
  end

  // display copy never sees the latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mon_link_error <= 16'h0000;
    end else if (ce) begin
      mon_link_error <= live_err;
    end
  end

  // ----------------------------------------------------------------
  // configuration ready and indirect access gate
  // ----------------------------------------------------------------
  logic access_ok;

  // registered so a glitching done line cannot open the gate early
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      board_ready <= 1'b0;
    end else if (ce) begin
      board_ready <= &device_done;
    end
  end

  // both must hold; a blocked access is still answered
  assign access_ok = board_ready && access_enable;

  // ----------------------------------------------------------------
  // test enable registers and link mapping
  // ----------------------------------------------------------------
  // six stored enable bits per group
  logic [5:0] test_a;
  logic [5:0] test_b;
  ldr_pkg::ldr_state_t state;
  logic test_wr_ok;

  // a pending device access owns the port; writes then are dropped
  assign test_wr_ok = ce && reg_wr && state == ldr_pkg::LDR_IDLE;

  function automatic logic [7:0] ldr_expand(input logic [5:0] bits);
    ldr_expand = {bits[5], bits[5], bits[4], bits[3], bits[2], bits[1], bits[0], bits[0]};
  endfunction

  // only six bits are stored; upper two read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_a <= ldr_pkg::RST_TEST;
      test_b <= ldr_pkg::RST_TEST;
    end else if (test_wr_ok) begin
      if (reg_addr == ldr_pkg::ADDR_TEST_A) begin
        test_a <= reg_wdata[5:0];
      end
      if (reg_addr == ldr_pkg::ADDR_TEST_B) begin
        test_b <= reg_wdata[5:0];
      end
    end
  end

  // per-link enables, also shown on the display feed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_pattern_enable <= 16'h0000;
      mon_test_enable <= 16'h0000;
    end else if (ce) begin
      test_pattern_enable <= {ldr_expand(test_b), ldr_expand(test_a)};
      mon_test_enable <= {ldr_expand(test_b), ldr_expand(test_a)};
    end
  end

  // ----------------------------------------------------------------
  // test pattern generator
  // ----------------------------------------------------------------
  // steps 0..7 walk the one, step 8 sends the link code
  logic [3:0] step;

  // one shared step counter keeps every link's pattern start aligned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step <= 4'h0;
    end else if (ce && pattern_step) begin
      if (step == ldr_pkg::PATTERN_LAST) begin
        step <= 4'h0;
      end else begin
        step <= step + 4'h1;
      end
    end
  end

  // walking one, then board position, group and link number
  generate
    for (gi = 0; gi < ldr_pkg::NUM_LINKS; gi++) begin : g_tx
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          test_word[gi] <= ldr_pkg::RST_BYTE;
        end else if (ce) begin
          if (!test_pattern_enable[gi]) begin
            test_word[gi] <= ldr_pkg::RST_BYTE;
          end else if (step <= ldr_pkg::WALK_LAST) begin
            test_word[gi] <= ldr_pkg::WALK_ONE << step[2:0];
          end else begin
            test_word[gi] <= {2'h0, board_position, 4'(gi)};
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register port and indirect access sequencer
  // ----------------------------------------------------------------
  // local pointer copy and data window decode
  logic [7:0] pointer;
  logic data_sel;

  // the data window only opens while gated access is allowed
  assign data_sel = (reg_addr == ldr_pkg::ADDR_DATA) && access_ok;

  // pointer is local; every accepted write is broadcast at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pointer <= ldr_pkg::RST_BYTE;
      lb_pointer <= ldr_pkg::RST_BYTE;
      lb_pointer_wr <= 1'b0;
    end else if (ce) begin
      lb_pointer_wr <= 1'b0;
      if (state == ldr_pkg::LDR_IDLE && reg_wr && reg_addr == ldr_pkg::ADDR_PTR && access_ok) begin
        pointer <= reg_wdata;
        lb_pointer <= reg_wdata;
        lb_pointer_wr <= 1'b1;
      end
    end
  end

  // device select follows the status/control field; pointer untouched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lb_select <= 4'h0;
    end else if (ce) begin
      lb_select <= device_select;
    end
  end

  // local registers answer next cycle; data access waits for device
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ldr_pkg::LDR_IDLE;
      reg_rdata <= ldr_pkg::RST_BYTE;
      reg_ack <= 1'b0;
      lb_wdata <= ldr_pkg::RST_BYTE;
      lb_wr <= 1'b0;
      lb_rd <= 1'b0;
    end else if (ce) begin
      reg_ack <= 1'b0;
      lb_wr <= 1'b0;
      lb_rd <= 1'b0;
      unique case (state)
        ldr_pkg::LDR_IDLE: begin
          // a write wins when both strobes are high
          if ((reg_rd || reg_wr) && data_sel) begin
            lb_wr <= reg_wr;
            lb_rd <= !reg_wr;
            lb_wdata <= reg_wdata;
            state <= ldr_pkg::LDR_WAIT_DEV;
          end else if (reg_rd || reg_wr) begin
            reg_ack <= 1'b1;
            reg_rdata <= ldr_pkg::RST_BYTE;
            if (reg_rd) begin
              unique case (reg_addr)
                ldr_pkg::ADDR_ERR_LOW: reg_rdata <= link_err[7:0];
                ldr_pkg::ADDR_ERR_HIGH: reg_rdata <= link_err[15:8];
                ldr_pkg::ADDR_PTR: reg_rdata <= access_ok ? pointer : ldr_pkg::RST_BYTE;
                ldr_pkg::ADDR_TEST_A: reg_rdata <= {2'h0, test_a};
                ldr_pkg::ADDR_TEST_B: reg_rdata <= {2'h0, test_b};
                default: reg_rdata <= ldr_pkg::RST_BYTE;
              endcase
            end
          end
        end
        ldr_pkg::LDR_WAIT_DEV: begin
          // the selected device must answer; no timeout is kept
          if (lb_ack) begin
            reg_rdata <= lb_rdata;
            reg_ack <= 1'b1;
            state <= ldr_pkg::LDR_IDLE;
          end
        end
      endcase
    end
  end

endmodule

/* File: ldr_dev_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// sixteen on-board devices behind the local bus
// ------------------------------------------------------------------
module ldr_dev_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [3:0] lb_select,
  input wire logic [7:0] lb_pointer,
  input wire logic lb_pointer_wr,
  input wire logic [7:0] lb_wdata,
  input wire logic lb_wr,
  input wire logic lb_rd,
  output logic [7:0] lb_rdata,
  output logic lb_ack
);
  logic [7:0] ptr [16];
  logic [7:0] mem [16][256];
  logic [2:0] cnt;
  logic busy, is_rd;
  logic [3:0] sel;
  // slow mode stretches the answer to test the waiting path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      lb_ack <= 1'b0;
      lb_rdata <= 8'h00;
    end else begin
      lb_ack <= 1'b0;
      lb_rdata <= ~lb_rdata; // released data never holds
      if (lb_pointer_wr) for (int i = 0; i < 16; i++) ptr[i] <= lb_pointer;
      if (lb_wr | lb_rd) begin
        busy <= 1'b1;
        is_rd <= lb_rd;
        sel <= lb_select;
        cnt <= slow ? 3'h5 : 3'h0;
        if (lb_wr) mem[lb_select][ptr[lb_select]] <= lb_wdata;
      end else if (busy && cnt != 3'h0) cnt <= cnt - 3'h1;
      else if (busy) begin
        busy <= 1'b0;
        lb_ack <= 1'b1;
        if (is_rd) lb_rdata <= mem[sel][ptr[sel]];
      end
    end
  end
endmodule

/* File: ldr_chk.sv */
`timescale 1ns/1ps
module ldr_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic access_enable,
  input wire logic [15:0] device_done,
  input wire logic board_ready,
  input wire logic [15:0] link_clk_missing,
  input wire logic [15:0] link_clk_out_of_range,
  input wire logic [15:0] link_dll_unlocked,
  input wire logic [15:0] mon_link_error,
  input wire logic [7:0] lb_pointer,
  input wire logic lb_pointer_wr,
  input wire logic lb_wr,
  input wire logic lb_rd,
  input wire logic [7:0] lb_rdata,
  input wire logic lb_ack,
  input wire logic [15:0] test_pattern_enable,
  input wire logic [15:0][7:0] test_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic last_rd;
  // remembers the kind of the open device access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) last_rd <= 1'b0;
    else if (lb_rd | lb_wr) last_rd <= lb_rd;
  end
  AST_PTR_COPY: assert property (lb_pointer_wr |-> $past(reg_wr && reg_addr == 5'h07)
    && lb_pointer == $past(reg_wdata)) else $error("pointer copy wrong");
  AST_PTR_GATE: assert property (lb_pointer_wr |-> $past(board_ready && access_enable))
    else $error("pointer copy while blocked");
  AST_DATA_GATE: assert property ((lb_rd || lb_wr) |-> $past(board_ready && access_enable
    && reg_addr == 5'h08 && (reg_rd || reg_wr))) else $error("device access while blocked");
  AST_READY: assert property (ce |=> board_ready == $past(&device_done))
    else $error("ready wrong");
  AST_DATA_RD: assert property (ce && lb_ack && last_rd |=> reg_ack && reg_rdata == $past(lb_rdata))
    else $error("device read data lost");
  AST_CLK_ERR: assert property (ce |=> (mon_link_error & $past(link_clk_missing | link_clk_out_of_range
    | link_dll_unlocked)) == $past(link_clk_missing | link_clk_out_of_range | link_dll_unlocked))
    else $error("clock fault not shown");
  AST_PAIRS: assert property (test_pattern_enable[0] == test_pattern_enable[1]
    && test_pattern_enable[6] == test_pattern_enable[7] && test_pattern_enable[8] == test_pattern_enable[9]
    && test_pattern_enable[14] == test_pattern_enable[15]) else $error("paired enables differ");
  AST_WORD_OFF: assert property (!test_pattern_enable[0] [*2] |-> test_word[0] == 8'h00)
    else $error("disabled link sends pattern");
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_ack, board_ready;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, lb_pointer, lb_wdata, lb_rdata;
  logic latch_enable = 1'b0, access_enable = 1'b0, ref_marker = 1'b0, pattern_step = 1'b0, slow = 1'b0;
  logic [3:0] device_select = 4'h0, lb_select;
  logic [15:0] device_done = 16'hFFFF, link_clk_missing = 16'h0002, link_clk_out_of_range = 16'h0200;
  logic [15:0] link_dll_unlocked = 16'h8000, link_sample = 16'hFFFF, link_marker = 16'h0000;
  logic [15:0] link_synced = 16'hFFF7, mon_link_error, mon_test_enable, test_pattern_enable;
  logic lb_pointer_wr, lb_wr, lb_rd, lb_ack;
  logic [1:0] board_position = 2'h2;
  logic [15:0][7:0] test_word;
  logic [2:0] ph = 3'h0;
  logic [7:0] w;
  int error_cnt = 0;
  int n_checks = 0;
  ldr_regs u_dut (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .latch_enable,
    .access_enable, .device_select, .device_done, .board_ready, .link_clk_missing, .link_clk_out_of_range,
    .link_dll_unlocked, .link_sample, .link_marker, .link_synced, .ref_marker, .mon_link_error, .mon_test_enable,
    .lb_select, .lb_pointer, .lb_pointer_wr, .lb_wdata, .lb_wr, .lb_rd, .lb_rdata, .lb_ack, .board_position,
    .pattern_step, .test_pattern_enable, .test_word);
  ldr_dev_model u_dev (.clk, .rst, .slow, .lb_select, .lb_pointer, .lb_pointer_wr, .lb_wdata, .lb_wr, .lb_rd,
    .lb_rdata, .lb_ack);
  always #20 clk = ~clk;
  // link 3 lacks markers, link 4 is one word late, link 5 has two per frame
  always @(posedge clk) begin
    ph <= (ph == 3'h6) ? 3'h0 : ph + 3'h1;
    ref_marker <= (ph == 3'h0);
    link_marker <= ({16{ph == 3'h0}} & 16'hFFE7) | ({16{ph == 3'h1}} & 16'h0010) | ({16{ph == 3'h3}} & 16'h0020);
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one register command; reads are compared, the answer is bounded
  task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // answer taken at the edge where ack is sampled high
    while (reg_ack !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("reg_ack", 16'h1, {15'h0, reg_ack});
    if (!wr) chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (40) @(posedge clk);
    acc(0, 5'h09, 0, 8'h00);
    acc(0, 5'h1F, 0, 8'h00);
    acc(0, 5'h05, 0, 8'h3A);
    acc(0, 5'h06, 0, 8'h82);
    chk("mon_link_error", 16'h823A, mon_link_error);
    latch_enable <= 1'b1;
    settle();
    link_clk_missing <= 16'h0000;
    settle();
    acc(0, 5'h05, 0, 8'h3A);
    chk("mon_link_error", 16'h8238, mon_link_error);
    latch_enable <= 1'b0;
    settle();
    acc(0, 5'h05, 0, 8'h38);
    acc(1, 5'h07, 8'h55, 0);
    acc(0, 5'h07, 0, 8'h00);
    access_enable <= 1'b1;
    device_done <= 16'h7FFF;
    settle();
    chk("board_ready", 16'h0, {15'h0, board_ready});
    acc(1, 5'h07, 8'h66, 0);
    acc(0, 5'h07, 0, 8'h00);
    device_done <= 16'hFFFF;
    device_select <= 4'h3;
    settle();
    acc(1, 5'h07, 8'h21, 0);
    chk("lb_pointer", 16'h0021, {8'h00, lb_pointer});
    acc(0, 5'h07, 0, 8'h21);
    acc(1, 5'h08, 8'hA5, 0);
    device_select <= 4'h7;
    slow <= 1'b1;
    settle();
    acc(1, 5'h08, 8'h3C, 0);
    device_select <= 4'h3;
    settle();
    acc(0, 5'h08, 0, 8'hA5);
    device_select <= 4'h7;
    settle();
    acc(0, 5'h08, 0, 8'h3C);
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 8'h03 : (k == 5) ? 8'hC0 : 8'h01 << (k + 1);
      acc(1, 5'h09, 8'hC0 | (8'h01 << k), 0);
      acc(1, 5'h0A, 8'hC0 | (8'h01 << k), 0);
      acc(0, 5'h0A, 0, 8'h01 << k);
      settle();
      chk("test_pattern_enable", {w, w}, test_pattern_enable);
      chk("mon_test_enable", {w, w}, mon_test_enable);
    end
    acc(1, 5'h09, 8'h3F, 0);
    acc(1, 5'h0A, 8'h3F, 0);
    settle();
    for (int s = 0; s < 10; s++) begin
      w = 8'h01 << (s % 9);
      chk("test_word", (s == 8) ? 16'h2F20 : {w, w}, {test_word[15], test_word[0]});
      pattern_step <= 1'b1;
      @(posedge clk);
      pattern_step <= 1'b0;
      settle();
    end
    // clock enable low must freeze the pattern despite a step request
    ce <= 1'b0;
    pattern_step <= 1'b1;
    settle();
    chk("test_word", 16'h0202, {test_word[15], test_word[0]});
    ce <= 1'b1;
    pattern_step <= 1'b0;
    close_out();
  end
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule
bind ldr_regs ldr_chk u_chk (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack,
  .access_enable, .device_done, .board_ready, .link_clk_missing, .link_clk_out_of_range, .link_dll_unlocked,
  .mon_link_error, .lb_pointer, .lb_pointer_wr, .lb_wr, .lb_rd, .lb_rdata, .lb_ack, .test_pattern_enable,
  .test_word);
